//--- design/atp_top.sv
// output conditioning for channel B: fine gain trim, offset bias target and test patterns
`timescale 1ns/10ps
`default_nettype none
`include "atp_map.svh"

module atp_top (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SOFT_RESET,
    input wire logic RES_12BIT,
    input wire logic INDEP_CTRL,
    input wire logic REG_WE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic [13:0] ADC_DATA,
    input wire logic ADC_VALID,
    output logic ADC_READY,
    output logic [13:0] OUT_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [13:0] TARGET_A,
    output logic [13:0] TARGET_B
);

    ////////////////////////////////////////////////////////////////////////////
    // state and carrier

    atp_pkg::atp_state_t s_q, s_d;
    logic push;
    logic [2:0] pat;
    logic [6:0] trim;
    atp_pkg::atp_word_t aligned;
    atp_pkg::atp_word_t gained;
    atp_pkg::atp_word_t cond;
    atp_pkg::atp_word_t mid;
    atp_pkg::atp_word_t bias_ext;
    logic signed [13:0] s_in;
    logic signed [21:0] prod;
    logic signed [8:0] add;
    logic signed [14:0] sum;
    logic signed [13:0] sat;

    atp_fifo_if #(.WIDTH(14)) fq ();

    atp_fifo #(.WIDTH(14), .DEPTH(`ATP_FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .srst(SRST),
        .port(fq.fifo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = addr == ofs;
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] addr, input atp_pkg::atp_state_t st);
        reg_read = 8'h00;
        if (hit(addr, `ATP_OFS_FINE_GAIN)) begin
            reg_read = st.fine_gain;
        end else if (hit(addr, `ATP_OFS_PATTERN)) begin
            reg_read = {5'h00, st.pattern[`ATP_PAT_MSB:`ATP_PAT_LSB]};
        end else if (hit(addr, `ATP_OFS_BIAS)) begin
            reg_read = {2'h0, st.bias[`ATP_BIAS_MSB:`ATP_BIAS_LSB]};
        end else if (hit(addr, `ATP_OFS_CUSTOM_HI)) begin
            reg_read = st.custom_hi;
        end else if (hit(addr, `ATP_OFS_CUSTOM_LO)) begin
            reg_read = st.custom_lo;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    always_comb begin
        s_d = s_q;
        pat = s_q.pattern[`ATP_PAT_MSB:`ATP_PAT_LSB];
        // the top trim bit is ignored: 128 steps only, so the trim stays below 0.134 dB
        trim = s_q.fine_gain[`ATP_TRIM_MSB:0];
        // 12-bit samples are lifted to the 14-bit grid so one saturating adder serves both
        aligned = RES_12BIT ? {ADC_DATA[11:0], 2'b00} : ADC_DATA;
        s_in = $signed({~aligned[13], aligned[12:0]});
        // coarse gain acts ahead of this block, the trim multiplies what it delivers
        prod = 22'(s_in) * $signed({15'h0000, trim});
        add = prod[21:`ATP_TRIM_SHIFT];
        sum = 15'(s_in) + 15'(add);
        if (sum > 15'sh1fff) begin
            sat = 14'sh1fff;
        end else if (sum < -15'sh2000) begin
            sat = -14'sh2000;
        end else begin
            sat = sum[13:0];
        end
        gained = {~sat[13], sat[12:0]};
        if (RES_12BIT) begin
            gained = {2'b00, gained[13:2]};
        end

        push = ADC_VALID && fq.push_ready;
        unique case (pat)
            `ATP_PAT_ZEROS: cond = 14'h0000;
            `ATP_PAT_ONES: cond = RES_12BIT ? `ATP_ONES_12 : `ATP_ONES_14;
            `ATP_PAT_TOGGLE: begin
                cond = RES_12BIT ? `ATP_TOGGLE_12 : `ATP_TOGGLE_14;
                if (s_q.toggle) begin
                    cond = RES_12BIT ? (cond ^ `ATP_ONES_12) : (cond ^ `ATP_ONES_14);
                end
            end
            `ATP_PAT_RAMP: cond = s_q.ramp;
            `ATP_PAT_CUSTOM: cond = {s_q.custom_hi[5:0], s_q.custom_lo};
            default: cond = gained;
        endcase
        if (RES_12BIT) begin
            cond = {2'b00, cond[11:0]};
        end

        // pattern sequences advance only on accepted samples (the 12-bit ramp on every fourth), so a stall never skips a step
        if (push) begin
            s_d.toggle = !s_q.toggle;
            if (!RES_12BIT) begin
                s_d.ramp = (s_q.ramp == `ATP_ONES_14) ? 14'h0000 : s_q.ramp + 14'h0001;
                s_d.presc = 2'h0;
            end else begin
                s_d.presc = s_q.presc + 2'h1;
                if (s_q.presc == `ATP_RAMP_DIV_12) begin
                    s_d.ramp = (s_q.ramp[11:0] == 12'hfff) ? 14'h0000 : {2'b00, s_q.ramp[11:0] + 12'h001};
                end
            end
        end
        if (pat != `ATP_PAT_RAMP) begin
            s_d.ramp = 14'h0000;
            s_d.presc = 2'h0;
        end

        mid = RES_12BIT ? `ATP_MID_12 : `ATP_MID_14;
        bias_ext = {{8{s_q.bias[`ATP_BIAS_MSB]}}, s_q.bias[`ATP_BIAS_MSB:`ATP_BIAS_LSB]};
        s_d.tgt_b = mid + bias_ext;
        s_d.tgt_a = INDEP_CTRL ? mid : mid + bias_ext;

        if (fq.pop_valid && (!s_q.out_valid || OUT_READY)) begin
            s_d.out_data = fq.pop_data;
            s_d.out_valid = 1'b1;
        end else if (OUT_READY) begin
            s_d.out_valid = 1'b0;
        end

        if (REG_WE) begin
            if (hit(REG_ADDR, `ATP_OFS_FINE_GAIN)) begin
                s_d.fine_gain = REG_WDATA;
            end
            if (hit(REG_ADDR, `ATP_OFS_PATTERN)) begin
                s_d.pattern = {5'h00, REG_WDATA[`ATP_PAT_MSB:`ATP_PAT_LSB]};
            end
            if (hit(REG_ADDR, `ATP_OFS_BIAS)) begin
                s_d.bias = {2'h0, REG_WDATA[`ATP_BIAS_MSB:`ATP_BIAS_LSB]};
            end
            if (hit(REG_ADDR, `ATP_OFS_CUSTOM_HI)) begin
                s_d.custom_hi = REG_WDATA;
            end
            if (hit(REG_ADDR, `ATP_OFS_CUSTOM_LO)) begin
                s_d.custom_lo = REG_WDATA;
            end
        end
        s_d.rdata = reg_read(REG_ADDR, s_q);
    end

    assign fq.push_valid = ADC_VALID;
    assign fq.push_data = cond;
    assign fq.pop_ready = !s_q.out_valid || OUT_READY;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q <= '0;
        end else if (SOFT_RESET) begin
            // software reset clears the settings, sequence state and targets; queued samples drain untouched
            s_q <= '0;
            s_q.out_data <= s_d.out_data;
            s_q.out_valid <= s_d.out_valid;
        end else begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA = s_q.rdata;
    assign ADC_READY = fq.push_ready;
    assign OUT_DATA = s_q.out_data;
    assign OUT_VALID = s_q.out_valid;
    assign TARGET_A = s_q.tgt_a;
    assign TARGET_B = s_q.tgt_b;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_zero_pattern: assert property (push && pat == `ATP_PAT_ZEROS |-> fq.push_data == 14'h0000)
        else $error("zero pattern not all zeros");

    a_ones_pattern: assert property (push && pat == `ATP_PAT_ONES && !RES_12BIT |-> fq.push_data == 14'h3fff)
        else $error("ones pattern not all ones");

    a_toggle_alt: assert property (push && pat == `ATP_PAT_TOGGLE && !RES_12BIT ##1
        push && pat == `ATP_PAT_TOGGLE && !RES_12BIT |-> fq.push_data == ~$past(fq.push_data))
        else $error("toggle pattern did not alternate");

    a_ramp_step: assert property (push && pat == `ATP_PAT_RAMP && !RES_12BIT && s_q.ramp != 14'h3fff ##1
        push && pat == `ATP_PAT_RAMP && !RES_12BIT |-> fq.push_data == $past(fq.push_data) + 14'h0001)
        else $error("14-bit ramp did not step by one");

    a_ramp_wrap: assert property (push && pat == `ATP_PAT_RAMP && !RES_12BIT && s_q.ramp == 14'h3fff
        |=> s_q.ramp == 14'h0000)
        else $error("ramp did not wrap to zero");

    a_ramp_hold12: assert property (pat == `ATP_PAT_RAMP && RES_12BIT && $stable(pat) && $stable(RES_12BIT)
        && $past(s_q.presc) != 2'h3 |-> $stable(s_q.ramp))
        else $error("12-bit ramp stepped before fourth sample");

    a_custom_word: assert property (push && pat == `ATP_PAT_CUSTOM && !RES_12BIT
        |-> fq.push_data == {s_q.custom_hi[5:0], s_q.custom_lo})
        else $error("custom pattern mismatch");

    a_unused_normal: assert property (push && pat[2:1] == 2'b11 |-> fq.push_data == gained)
        else $error("unused code not treated as normal");

    // trim only adds gain, so a sample at or above mid-scale never comes out smaller
    a_trim_upward: assert property (push && pat == `ATP_PAT_NORMAL && !RES_12BIT && ADC_DATA[13]
        |-> fq.push_data >= ADC_DATA)
        else $error("fine trim reduced a sample above mid-scale");

    // target lags the bias register by one cycle; a software reset clears the target itself
    a_target_bias: assert property (!RES_12BIT && !SOFT_RESET ##1 !RES_12BIT
        |-> TARGET_B == 14'h2000 + {{8{$past(s_q.bias[5])}}, $past(s_q.bias[5:0])})
        else $error("channel B target not mid-scale plus bias");

    a_common_bias: assert property (!INDEP_CTRL ##1 1'b1 |-> TARGET_A == TARGET_B)
        else $error("common bias not applied to both channels");

    a_soft_clear: assert property (SOFT_RESET |=> s_q.fine_gain == 8'h00 && s_q.pattern == 8'h00)
        else $error("software reset did not clear registers");

endmodule

`default_nettype wire

//--- design/atp_map.svh
// offsets, field positions, reset values and pattern codes of the output trim and pattern block
`ifndef ATP_MAP_SVH
`define ATP_MAP_SVH

`define ATP_OFS_CUSTOM_HI 8'h51
`define ATP_OFS_CUSTOM_LO 8'h52
`define ATP_OFS_FINE_GAIN 8'h6a
`define ATP_OFS_PATTERN 8'h75
`define ATP_OFS_BIAS 8'h76

`define ATP_RST_REG 8'h00

`define ATP_PAT_LSB 0
`define ATP_PAT_MSB 2
`define ATP_BIAS_LSB 0
`define ATP_BIAS_MSB 5
`define ATP_TRIM_MSB 6
`define ATP_TRIM_SHIFT 13

`define ATP_PAT_NORMAL 3'h0
`define ATP_PAT_ZEROS 3'h1
`define ATP_PAT_ONES 3'h2
`define ATP_PAT_TOGGLE 3'h3
`define ATP_PAT_RAMP 3'h4
`define ATP_PAT_CUSTOM 3'h5

`define ATP_TOGGLE_14 14'h1555
`define ATP_TOGGLE_12 14'h0555
`define ATP_ONES_14 14'h3fff
`define ATP_ONES_12 14'h0fff
`define ATP_MID_14 14'h2000
`define ATP_MID_12 14'h0800
`define ATP_RAMP_DIV_12 2'h3

`define ATP_FIFO_DEPTH 8

`endif

//--- design/atp_pkg.sv
// types shared by the output trim and pattern block
package atp_pkg;

    typedef logic [13:0] atp_word_t;

    typedef struct packed {
        logic [7:0] fine_gain;
        logic [7:0] pattern;
        logic [7:0] bias;
        logic [7:0] custom_hi;
        logic [7:0] custom_lo;
        logic [7:0] rdata;
        logic toggle;
        atp_word_t ramp;
        logic [1:0] presc;
        atp_word_t tgt_a;
        atp_word_t tgt_b;
        atp_word_t out_data;
        logic out_valid;
    } atp_state_t;

endpackage

//--- design/atp_fifo_if.sv
// carrier between the conditioning logic and its sample fifo
`timescale 1ns/10ps
`default_nettype none

interface atp_fifo_if #(parameter int WIDTH = 14);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport src (output push_valid, output push_data, output pop_ready,
                 input push_ready, input pop_valid, input pop_data);
    modport fifo (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data);
endinterface

`default_nettype wire

//--- design/atp_fifo.sv
// sample fifo with registered ready and valid flags
`timescale 1ns/10ps
`default_nettype none

module atp_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    atp_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic rdy;
        logic vld;
    } atp_fifo_st_t;

    atp_fifo_st_t s_q, s_d;
    logic push, pop;

    always_comb begin
        s_d = s_q;
        // flags are flops so that ready never depends on the drain side in the same cycle
        push = port.push_valid && s_q.rdy;
        pop = port.pop_ready && s_q.vld;
        if (push) begin
            s_d.mem[s_q.wr] = port.push_data;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_d.rdy = s_d.cnt < (AW+1)'(DEPTH);
        s_d.vld = s_d.cnt != '0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign port.push_ready = s_q.rdy;
    assign port.pop_valid = s_q.vld;
    assign port.pop_data = s_q.mem[s_q.rd];

endmodule

`default_nettype wire

//--- verif/atp_capture_model.sv
// capture side model: takes conditioned samples, answering promptly, slowly or not at all
`timescale 1ns/10ps
`default_nettype none

module atp_capture_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [13:0] out_data,
    input wire logic out_valid,
    input wire logic slow,
    input wire logic hold,
    output logic ready,
    output logic [13:0] cap_data,
    output logic cap_stb
);
    // slow mode offers ready every other cycle, so stalls hit a full output stage
    always_ff @(posedge clk) begin
        if (srst) begin
            ready <= 1'b0;
            cap_stb <= 1'b0;
            cap_data <= 14'h0000;
        end else begin
            cap_stb <= out_valid && ready;
            cap_data <= out_data;
            ready <= !hold && (!slow || !ready);
        end
    end
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench: register access, targets, trim and pattern streams
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end

module tb_top;
    logic clk = 1'b0, srst = 1'b1, soft_reset = 1'b0, res_12bit = 1'b0, indep_ctrl = 1'b0;
    logic reg_we = 1'b0, adc_valid = 1'b0, adc_ready, out_valid, out_ready, slow = 1'b0, hold = 1'b0, cap_stb;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [13:0] adc_data = 14'h0000, out_data, target_a, target_b, cap_data;
    logic [13:0] exp_q[$];
    int err_total = 0, comparisons = 0, cycles = 0;
    logic [7:0] addrs[6] = '{8'h51, 8'h52, 8'h6a, 8'h75, 8'h76, 8'h10};
    logic [5:0] bv[4] = '{6'h1f, 6'h00, 6'h3f, 6'h20};

    atp_top dut (.CLK(clk), .SRST(srst), .SOFT_RESET(soft_reset), .RES_12BIT(res_12bit),
        .INDEP_CTRL(indep_ctrl), .REG_WE(reg_we), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .ADC_DATA(adc_data), .ADC_VALID(adc_valid), .ADC_READY(adc_ready),
        .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(out_ready), .TARGET_A(target_a),
        .TARGET_B(target_b));
    atp_capture_model cap (.clk(clk), .srst(srst), .out_data(out_data), .out_valid(out_valid),
        .slow(slow), .hold(hold), .ready(out_ready), .cap_data(cap_data), .cap_stb(cap_stb));

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ceiling covers two full ramp wraps plus the short tests
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            err_total++;
            conclude();
        end
    end

    // every captured word is matched against the expected stream in order
    always @(posedge clk) begin
        if (cap_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("extra word", 14'h0000, 14'h3fff)
            end else begin
                `CHK("out_data", exp_q.pop_front(), cap_data)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic r12);
        srst <= 1'b1;
        res_12bit <= r12;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    // valid stays up between calls so bursts run back to back; idle lowers it
    task automatic send(input logic [13:0] d, input logic [13:0] e);
        int n;
        n = 0;
        adc_valid <= 1'b1;
        adc_data <= d;
        do begin
            @(posedge clk);
            n++;
        end while (adc_ready !== 1'b1 && n < 50);
        exp_q.push_back(e);
    endtask

    task automatic idle();
        adc_valid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        `CHK("left over", 32'd0, 32'(exp_q.size()))
    endtask

    function automatic logic [13:0] pexp(input logic [2:0] c, input logic [13:0] d);
        case (c)
            3'h1: pexp = 14'h0000;
            3'h2: pexp = res_12bit ? 14'h0fff : 14'h3fff;
            3'h5: pexp = res_12bit ? 14'h0bcd : 14'h2bcd;
            default: pexp = d;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        do_reset(1'b0);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        wr(8'h75, 8'hff);
        rd(8'h75, 8'h07);
        wr(8'h76, 8'hff);
        rd(8'h76, 8'h3f);
        foreach (bv[i]) begin
            wr(8'h76, {2'b00, bv[i]});
            repeat (2) @(posedge clk);
            `CHK("target_b", 14'h2000 + {{8{bv[i][5]}}, bv[i]}, target_b)
            `CHK("target_a", 14'h2000 + {{8{bv[i][5]}}, bv[i]}, target_a)
        end
        indep_ctrl <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("target_a indep", 14'h2000, target_a)
        wr(8'h75, 8'h00);
        wr(8'h6a, 8'hc0); // top bit ignored, trim of 64
        slow <= 1'b1;
        send(14'h3000, 14'h3020);
        send(14'h2000, 14'h2000);
        send(14'h1000, 14'h0fe0);
        idle();
        wr(8'h6a, 8'h00);
        wr(8'h51, 8'h2b);
        wr(8'h52, 8'hcd);
        for (int c = 0; c < 8; c++) begin
            if (c != 3 && c != 4) begin
                wr(8'h75, 8'(c));
                send(14'h0abc, pexp(3'(c), 14'h0abc));
                send(14'h1234, pexp(3'(c), 14'h1234));
                idle();
            end
        end
        // fill with the capture side stalled: 8 in the fifo plus the output register
        wr(8'h75, 8'h00);
        hold <= 1'b1;
        adc_valid <= 1'b1;
        adc_data <= 14'h0123;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            if (adc_ready === 1'b1) begin
                n++;
                exp_q.push_back(14'h0123);
            end
        end
        adc_valid <= 1'b0;
        hold <= 1'b0;
        `CHK("taken while stalled", 32'd9, 32'(n))
        drain();
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        @(posedge clk);
        rd(8'h75, 8'h00);
        wr(8'h75, 8'h03);
        for (int k = 0; k < 4; k++) send(14'h0000, k[0] ? 14'h2aaa : 14'h1555);
        idle();
        slow <= 1'b0;
        wr(8'h75, 8'h04);
        for (int k = 0; k < 16386; k++) send(k[13:0], 14'(k % 16384));
        idle();
        drain();
        do_reset(1'b1);
        wr(8'h75, 8'h03);
        for (int k = 0; k < 4; k++) send(14'h0000, k[0] ? 14'h0aaa : 14'h0555);
        idle();
        wr(8'h51, 8'h2b);
        wr(8'h52, 8'hcd);
        for (int c = 2; c < 6; c += 3) begin
            wr(8'h75, 8'(c));
            send(14'h0abc, pexp(3'(c), 14'h0abc));
            idle();
        end
        wr(8'h76, 8'h3f);
        repeat (2) @(posedge clk);
        `CHK("target_b 12", 14'h07ff, target_b)
        wr(8'h75, 8'h04);
        for (int k = 0; k < 16388; k++) send(14'h0000, 14'((k / 4) % 4096));
        idle();
        drain();
        conclude();
    end
endmodule

`default_nettype wire
